// [hw/mdc_backoff.sv]
`timescale 1ns/1ns
`default_nettype none
// Collision backoff timer: counts whole slot times drawn from an LFSR.
module mdc_backoff
   import mdc_pkg::*;
#(
   parameter int SLOT_CNT = mdc_pkg::SLOT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Control
   input wire logic coll_pulse,
   input wire logic tx_done,
   input wire logic prio_en,
   input wire logic seed_wr,
   input wire logic [7:0] seed_data,
   // Status
   output logic busy,
   output logic [4:0] coll_count
);

   typedef enum logic [1:0] {
      MDC_BO_IDLE = 2'b00,
      MDC_BO_WAIT = 2'b01
   } mdc_bo_e;

   mdc_bo_e state_r, state_nxt;
   logic [15:0] lfsr_r, lfsr_nxt;
   logic [10:0] slots_r, slots_nxt;
   logic [15:0] cyc_r, cyc_nxt;
   logic [4:0] coll_r, coll_nxt;
   logic busy_r, busy_nxt;
   logic [3:0] exp_v;
   logic [10:0] mask_v;

   // Exponent with the low-priority offset for early collisions
   always_comb begin
      exp_v = (coll_r >= 5'h0A) ? BACKOFF_CAP_EXP : coll_r[3:0] + 4'h1;
      if (prio_en && coll_r < OFFSET_COLLS) begin
         exp_v = (coll_r[3:0] + 4'h1 + OFFSET_EXTRA > BACKOFF_CAP_EXP) ?
            BACKOFF_CAP_EXP : coll_r[3:0] + 4'h1 + OFFSET_EXTRA;
      end
      mask_v = 11'((12'h001 << exp_v) - 12'h001);
   end

   // Next-state logic for the slot timer
   always_comb begin
      state_nxt = state_r;
      lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      slots_nxt = slots_r;
      cyc_nxt = cyc_r;
      coll_nxt = coll_r;
      if (seed_wr) begin
         lfsr_nxt = {lfsr_r[15:8], seed_data | 8'h01};
      end
      unique case (state_r)
         MDC_BO_IDLE: begin
            if (coll_pulse) begin
               slots_nxt = lfsr_r[10:0] & mask_v;
               cyc_nxt = 16'(SLOT_CNT - 1);
               coll_nxt = coll_r + 5'h01;
               state_nxt = MDC_BO_WAIT;
            end
         end
         MDC_BO_WAIT: begin
            // Each unit of delay is one full slot time
            if (slots_r == 11'h000) begin
               state_nxt = MDC_BO_IDLE;
            end else if (cyc_r == 16'h0000) begin
               cyc_nxt = 16'(SLOT_CNT - 1);
               slots_nxt = slots_r - 11'h001;
            end else begin
               cyc_nxt = cyc_r - 16'h0001;
            end
         end
      endcase
      if (tx_done) begin
         coll_nxt = 5'h00;
      end
      busy_nxt = (state_nxt == MDC_BO_WAIT);
   end

   // State registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= MDC_BO_IDLE;
         lfsr_r <= LFSR_RST;
         slots_r <= 11'h000;
         cyc_r <= 16'h0000;
         coll_r <= 5'h00;
         busy_r <= 1'b0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         lfsr_r <= lfsr_nxt;
         slots_r <= slots_nxt;
         cyc_r <= cyc_nxt;
         coll_r <= coll_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign busy = busy_r; // Registered so the top output comes from a flop
   assign coll_count = coll_r;

   chk_offset_cap: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && state_r == MDC_BO_IDLE && coll_pulse && prio_en && coll_r == 5'h00)
      |=> (slots_r <= 11'h00F))
      else $error("offset backoff exceeded 2^4 slots");

endmodule
`default_nettype wire

// [hw/mdc_pkg.sv]
package mdc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte-wide offsets on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [3:0] TX_SETUP_OFS = 4'hD;
   localparam logic [3:0] DMA_SETUP_OFS = 4'hE;
   localparam logic [3:0] STATUS_OFS = 4'hF;
   localparam logic [3:0] RSA_LO_OFS = 4'h8;
   localparam logic [3:0] RSA_HI_OFS = 4'h9;
   localparam logic [3:0] CMD_OFS = 4'h0;
   localparam logic [3:0] SEED_OFS = 4'hA;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int WIDTH_SEL_BIT = 0;
   localparam int LANE_ORDER_BIT = 1;
   localparam int LONG_ADDR_BIT = 2;
   localparam int LSN_BIT = 3;
   localparam int AUTO_RM_BIT = 4;
   localparam int FT_LO_BIT = 5;
   localparam int CRC_BIT = 0;
   localparam int LB_LO_BIT = 1;
   localparam int REMOTE_OFF_BIT = 3;
   localparam int PRIO_BIT = 4;
   localparam int SEND_CMD_BIT = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] DMA_SETUP_RST = 8'h04;
   localparam logic [7:0] TX_SETUP_RST = 8'h00;
   localparam logic [15:0] LFSR_RST = 16'hACE1;

   // ----------------------------------------------------------------
   // Thresholds, hashes, backoff
   // ----------------------------------------------------------------
   localparam logic [3:0] FIFO_SPAN_BYTES = 4'hD;
   localparam logic [5:0] HASH_TX_OFF = 6'h3E;
   localparam logic [5:0] HASH_TX_ON = 6'h3F;
   localparam logic [3:0] BACKOFF_CAP_EXP = 4'hA;
   localparam logic [3:0] OFFSET_EXTRA = 4'h3;
   localparam logic [4:0] OFFSET_COLLS = 5'h03;
   localparam int CLK_MHZ = 125;
   localparam int SLOT_TIME_NS = 51200;
   localparam int SLOT_CYCLES = (SLOT_TIME_NS * CLK_MHZ) / 1000;

   // ----------------------------------------------------------------
   // Loopback modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MDC_LB_NORMAL = 2'b00,
      MDC_LB_CORE = 2'b01,
      MDC_LB_CODEC = 2'b10,
      MDC_LB_EXT = 2'b11
   } mdc_lb_e;

endpackage

// [hw/mdc_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Transfer-width bit picks byte (0) or word (1) transfers for remote and local DMA.
// - In word mode at most 32k words are addressed and A0 stays low.
// - Byte-order bit 0 puts the MS byte on AD15-8, 1 swaps lanes; ignored in byte mode.
// - Long-address bit 0 gives dual 16-bit addressing, 1 drives A31-A16 from the remote start address.
// - The long-address bit powers up set.
// - Loopback select low enables loopback, together with the loopback mode field.
// - Auto-remove set lets the send command start remote DMA; clear ignores it.
// - Threshold codes 0-3 mean 1,2,4,6 words or 2,4,8,12 bytes.
// - Bus is requested at the receive threshold; the transmit threshold is 13 bytes less it.
// - CRC-inhibit 0 appends the CRC, 1 omits it, in any loopback mode too.
// - Loop mode 00 normal, 01 core, 10 codec with loopback pin high, 11 external.
// - Both loop mode bits power up clear.
// - Remote disable set: hash 62 stops the transmitter, hash 63 or clearing the bit restarts it.
// - Backoff priority set widens backoff to 2^min(3+n,10) slots for the first three collisions.
// - Backoff timing uses a 51.2 us slot time.
module mdc_top
   import mdc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // DMA address and data path
   input wire logic [15:0] dma_addr,
   input wire logic [15:0] dma_data_in,
   output logic [31:0] mem_addr,
   output logic [15:0] mem_data,
   output logic word_mode,
   // FIFO levels (bytes) and bus request
   input wire logic [3:0] fifo_level,
   input wire logic fifo_tx_dir,
   output logic bus_req,
   // Receive events, same clock
   input wire logic mcast_hit,
   input wire logic [5:0] mcast_hash,
   // Transmit events, same clock
   input wire logic coll_pulse,
   input wire logic tx_done,
   // Line-side controls
   output logic crc_append,
   output logic [1:0] loop_mode,
   output logic loopback_pin_out,
   output logic tx_enable,
   output logic backoff_busy,
   output logic remote_dma_start
);

   logic [7:0] dma_setup_reg_r, dma_setup_reg_nxt;
   logic [7:0] tx_setup_reg_r, tx_setup_reg_nxt;
   logic [15:0] remote_start_addr_r, remote_start_addr_nxt;
   logic tx_off_r, tx_off_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic [15:0] data_r, data_nxt;
   logic bus_req_r, bus_req_nxt;
   logic start_r, start_nxt;
   logic [1:0] lb_r, lb_nxt;
   logic lbpin_r, lbpin_nxt;
   logic crc_r, crc_nxt;
   logic txen_r, txen_nxt;
   logic bo_busy;
   logic [4:0] coll_count;
   logic transfer_width_sel, byte_lane_order_sel, long_addr_sel, loopback_sel_n;
   logic auto_remove, fifo_thresh_lo, fifo_thresh_hi;
   logic loop_mode_lo, loop_mode_hi, remote_tx_disable_en, backoff_priority_en;
   logic [3:0] rx_thresh;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Threshold in bytes; words count double so one compare serves both modes
   function automatic logic [3:0] thresh_bytes(input logic [1:0] code);
      logic [3:0] v;
      v = 4'h2;
      unique case (code)
         2'b00: v = 4'h2;
         2'b01: v = 4'h4;
         2'b10: v = 4'h8;
         2'b11: v = 4'hC;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   assign transfer_width_sel = dma_setup_reg_r[WIDTH_SEL_BIT];
   assign byte_lane_order_sel = dma_setup_reg_r[LANE_ORDER_BIT];
   assign long_addr_sel = dma_setup_reg_r[LONG_ADDR_BIT];
   assign loopback_sel_n = dma_setup_reg_r[LSN_BIT];
   assign auto_remove = dma_setup_reg_r[AUTO_RM_BIT];
   assign fifo_thresh_lo = dma_setup_reg_r[FT_LO_BIT];
   assign fifo_thresh_hi = dma_setup_reg_r[FT_LO_BIT + 1];
   assign loop_mode_lo = tx_setup_reg_r[LB_LO_BIT];
   assign loop_mode_hi = tx_setup_reg_r[LB_LO_BIT + 1];
   assign remote_tx_disable_en = tx_setup_reg_r[REMOTE_OFF_BIT];
   assign backoff_priority_en = tx_setup_reg_r[PRIO_BIT];
   assign rx_thresh = thresh_bytes({fifo_thresh_hi, fifo_thresh_lo});

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------

   // Writes and read data; reads are one cycle late, never stalled
   always_comb begin
      dma_setup_reg_nxt = dma_setup_reg_r;
      tx_setup_reg_nxt = tx_setup_reg_r;
      remote_start_addr_nxt = remote_start_addr_r;
      start_nxt = 1'b0;
      rdata_nxt = 8'h00;
      if (reg_wr) begin
         unique case (reg_addr)
            DMA_SETUP_OFS: dma_setup_reg_nxt = {1'b0, reg_wdata[6:0]};
            TX_SETUP_OFS: tx_setup_reg_nxt = {3'b000, reg_wdata[4:0]};
            RSA_LO_OFS: remote_start_addr_nxt[7:0] = reg_wdata;
            RSA_HI_OFS: remote_start_addr_nxt[15:8] = reg_wdata;
            // Send is dropped unless auto-remove is armed
            CMD_OFS: start_nxt = reg_wdata[SEND_CMD_BIT] & auto_remove;
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            DMA_SETUP_OFS: rdata_nxt = dma_setup_reg_r;
            RSA_LO_OFS: rdata_nxt = remote_start_addr_r[7:0];
            RSA_HI_OFS: rdata_nxt = remote_start_addr_r[15:8];
            STATUS_OFS: rdata_nxt = {2'b00, bo_busy, coll_count[3:0], ~tx_off_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Transmitter disable by multicast hash
   // ----------------------------------------------------------------
   always_comb begin
      tx_off_nxt = tx_off_r;
      if (!remote_tx_disable_en) begin
         tx_off_nxt = 1'b0;
      end else if (mcast_hit && mcast_hash == HASH_TX_OFF) begin
         tx_off_nxt = 1'b1;
      end else if (mcast_hit && mcast_hash == HASH_TX_ON) begin
         tx_off_nxt = 1'b0;
      end
      // A write clearing the enable also releases the transmitter
      if (reg_wr && reg_addr == TX_SETUP_OFS && !reg_wdata[REMOTE_OFF_BIT]) begin
         tx_off_nxt = 1'b0;
      end
      txen_nxt = ~tx_off_nxt;
   end

   // ----------------------------------------------------------------
   // Data path: address, lanes, thresholds, line controls
   // ----------------------------------------------------------------
   always_comb begin
      addr_nxt = 32'h0000_0000;
      // Upper lines come from the remote start only in long mode
      if (long_addr_sel) begin
         addr_nxt[31:16] = remote_start_addr_r;
      end
      if (transfer_width_sel) begin
         addr_nxt[15:0] = {dma_addr[15:1], 1'b0};
      end else begin
         addr_nxt[15:0] = dma_addr;
      end
      // Lane swap only means something with a 16-bit bus
      if (transfer_width_sel && byte_lane_order_sel) begin
         data_nxt = {dma_data_in[7:0], dma_data_in[15:8]};
      end else if (transfer_width_sel) begin
         data_nxt = dma_data_in;
      end else begin
         data_nxt = {8'h00, dma_data_in[7:0]};
      end
      if (fifo_tx_dir) begin
         bus_req_nxt = (fifo_level >= 4'(FIFO_SPAN_BYTES - rx_thresh));
      end else begin
         bus_req_nxt = (fifo_level >= rx_thresh);
      end
      // Mode field only acts while loopback select is low
      lb_nxt = loopback_sel_n ? MDC_LB_NORMAL : {loop_mode_hi, loop_mode_lo};
      lbpin_nxt = (lb_nxt == MDC_LB_CODEC);
      crc_nxt = ~tx_setup_reg_r[CRC_BIT];
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         dma_setup_reg_r <= DMA_SETUP_RST;
         tx_setup_reg_r <= TX_SETUP_RST;
         remote_start_addr_r <= 16'h0000;
         tx_off_r <= 1'b0;
         rdata_r <= 8'h00;
         addr_r <= 32'h0000_0000;
         data_r <= 16'h0000;
         bus_req_r <= 1'b0;
         start_r <= 1'b0;
         lb_r <= MDC_LB_NORMAL;
         lbpin_r <= 1'b0;
         crc_r <= 1'b1;
         txen_r <= 1'b1;
      end else if (clk_en) begin
         dma_setup_reg_r <= dma_setup_reg_nxt;
         tx_setup_reg_r <= tx_setup_reg_nxt;
         remote_start_addr_r <= remote_start_addr_nxt;
         tx_off_r <= tx_off_nxt;
         rdata_r <= rdata_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         bus_req_r <= bus_req_nxt;
         start_r <= start_nxt;
         lb_r <= lb_nxt;
         lbpin_r <= lbpin_nxt;
         crc_r <= crc_nxt;
         txen_r <= txen_nxt;
      end
   end

   // Backoff engine
   mdc_backoff u_backoff (
      .clock(clock),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .coll_pulse(coll_pulse),
      .tx_done(tx_done),
      .prio_en(backoff_priority_en),
      .seed_wr(reg_wr && reg_addr == SEED_OFS),
      .seed_data(reg_wdata),
      .busy(bo_busy),
      .coll_count(coll_count)
   );

   assign reg_rdata = rdata_r;
   assign mem_addr = addr_r;
   assign mem_data = data_r;
   assign word_mode = transfer_width_sel;
   assign bus_req = bus_req_r;
   assign remote_dma_start = start_r;
   assign loop_mode = lb_r;
   assign loopback_pin_out = lbpin_r;
   assign crc_append = crc_r;
   assign tx_enable = txen_r;
   assign backoff_busy = bo_busy;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_word_a0_low: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && transfer_width_sel) |=> (mem_addr[0] == 1'b0))
      else $error("A0 high in word mode");
   chk_long_upper: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && !long_addr_sel) |=> (mem_addr[31:16] == 16'h0000))
      else $error("upper address driven in dual mode");
   chk_lane_swap: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && transfer_width_sel && byte_lane_order_sel)
      |=> (mem_data == {$past(dma_data_in[7:0]), $past(dma_data_in[15:8])}))
      else $error("lanes not swapped");
   chk_send_gate: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && reg_wr && reg_addr == CMD_OFS && !auto_remove) |=> !remote_dma_start)
      else $error("send executed without auto-remove");
   chk_codec_pin: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && !loopback_sel_n)
      |=> (loopback_pin_out == ($past({loop_mode_hi, loop_mode_lo}) == MDC_LB_CODEC)))
      else $error("loopback pin mismatch");
   chk_loop_norm: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && loopback_sel_n) |=> (loop_mode == MDC_LB_NORMAL))
      else $error("loopback active with select high");
   chk_tx_kill: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && remote_tx_disable_en && mcast_hit && mcast_hash == HASH_TX_OFF && !reg_wr)
      |=> !tx_enable)
      else $error("hash 62 did not disable transmitter");
   chk_crc_follow: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en |=> (crc_append == !$past(tx_setup_reg_r[CRC_BIT])))
      else $error("crc append not following inhibit");
   chk_rx_thresh: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && !fifo_tx_dir && fifo_level < rx_thresh) |=> !bus_req)
      else $error("bus request below threshold");
   chk_tx_thresh: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && fifo_tx_dir && fifo_level >= FIFO_SPAN_BYTES - rx_thresh) |=> bus_req)
      else $error("no bus request at transmit threshold");
   chk_send_fire: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && reg_wr && reg_addr == CMD_OFS && reg_wdata[SEND_CMD_BIT] && auto_remove) |=> remote_dma_start)
      else $error("send not executed with auto-remove set");
   chk_tx_wake: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && mcast_hit && mcast_hash == HASH_TX_ON) |=> tx_enable)
      else $error("hash 63 did not enable transmitter");
   chk_byte_hi_zero: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && !transfer_width_sel) |=> (mem_data[15:8] == 8'h00))
      else $error("upper lane driven in byte mode");

endmodule
`default_nettype wire

// [verif/mdc_mem_peer.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Buffer-memory side: local DMA and FIFO
// ----------------------------------------
module mdc_mem_peer (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Local DMA and FIFO state
   output logic [15:0] dma_addr,
   output logic [15:0] dma_data_in,
   output logic [3:0] fifo_level,
   output logic fifo_tx_dir
);
   logic [31:0] st_r;
   logic [31:0] st_nxt;
   // New values every cycle, so a stale multi-bit output seldom matches by luck
   always_comb begin
      st_nxt = {st_r[30:0], st_r[31] ^ st_r[21] ^ st_r[1] ^ st_r[0]};
   end
   // State changes only just after the edge
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= 32'h0000_0001;
      end else begin
         st_r <= st_nxt;
      end
   end
   // Outputs
   assign dma_addr = st_r[15:0];
   assign dma_data_in = st_r[31:16] ^ {8'h00, st_r[7:0]};
   assign fifo_level = st_r[19:16];
   assign fifo_tx_dir = st_r[24];
endmodule
`default_nettype wire

// [verif/tb_mac_dma_and_transmit_config.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR at %0t: value %0h, expected %0h", $time, got, exp); end end
module tb_mac_dma_and_transmit_config;
   import mdc_pkg::*;
   logic clock, sys_rst, clk_en, reg_wr, reg_rd, word_mode, fifo_tx_dir, bus_req;
   logic mcast_hit, coll_pulse, tx_done, crc_append, loopback_pin_out, tx_enable;
   logic backoff_busy, remote_dma_start, snap;
   logic [3:0] reg_addr, fifo_level;
   logic [7:0] reg_wdata, reg_rdata, cfg, d;
   logic [15:0] dma_addr, dma_data_in, mem_data, rsa;
   logic [31:0] mem_addr, seed;
   logic [5:0] mcast_hash;
   logic [1:0] loop_mode;
   int bad_count, checks_done, cycles, n;
   // ----------------------------------------
   // Design, memory side and clock
   // ----------------------------------------
   mdc_top uut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dma_addr(dma_addr), .dma_data_in(dma_data_in), .mem_addr(mem_addr), .mem_data(mem_data),
      .word_mode(word_mode), .fifo_level(fifo_level), .fifo_tx_dir(fifo_tx_dir), .bus_req(bus_req),
      .mcast_hit(mcast_hit), .mcast_hash(mcast_hash), .coll_pulse(coll_pulse), .tx_done(tx_done),
      .crc_append(crc_append), .loop_mode(loop_mode), .loopback_pin_out(loopback_pin_out),
      .tx_enable(tx_enable), .backoff_busy(backoff_busy), .remote_dma_start(remote_dma_start));
   mdc_mem_peer peer (.clock(clock), .sys_rst(sys_rst), .dma_addr(dma_addr),
      .dma_data_in(dma_data_in), .fifo_level(fifo_level), .fifo_tx_dir(fifo_tx_dir));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Hang guard; the longest wait is one backoff slot
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // Expectations
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] exp_addr(input logic [7:0] c, input logic [15:0] r, input logic [15:0] a);
      return {c[LONG_ADDR_BIT] ? r : 16'h0000, a[15:1], a[0] & !c[WIDTH_SEL_BIT]};
   endfunction
   function automatic logic [15:0] exp_data(input logic [7:0] c, input logic [15:0] x);
      if (!c[WIDTH_SEL_BIT]) return {8'h00, x[7:0]};
      return c[LANE_ORDER_BIT] ? {x[7:0], x[15:8]} : x;
   endfunction
   // Threshold in bytes; transmit side uses its complement to 13
   function automatic logic exp_req(input logic [7:0] c, input logic [3:0] l, input logic dir);
      logic [3:0] t;
      t = c[6] ? (c[5] ? 4'hC : 4'h8) : (c[5] ? 4'h4 : 4'h2);
      return dir ? (l >= 4'hD - t) : (l >= t);
   endfunction
   // ----------------------------------------
   // Register port and event tasks
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
      snap = remote_dma_start;
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
      @(posedge clock);
   endtask
   task automatic hit(input logic [5:0] h, input logic e);
      mcast_hash <= h;
      mcast_hit <= 1'b1;
      @(posedge clock);
      mcast_hit <= 1'b0;
      @(posedge clock);
      #1;
      `CHK(tx_enable, e)
   endtask
   // Inputs captured at the edge, outputs compared once it has settled
   task automatic chk_path(input int cnt);
      logic [15:0] a, x;
      logic [3:0] l;
      logic dir;
      repeat (cnt) begin
         @(posedge clock);
         a = dma_addr;
         x = dma_data_in;
         l = fifo_level;
         dir = fifo_tx_dir;
         #1;
         `CHK(mem_addr, exp_addr(cfg, rsa, a))
         `CHK(mem_data, exp_data(cfg, x))
         `CHK(bus_req, exp_req(cfg, l, dir))
         `CHK(word_mode, cfg[WIDTH_SEL_BIT])
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      mcast_hit = 1'b0;
      mcast_hash = 6'h00;
      coll_pulse = 1'b0;
      tx_done = 1'b0;
      seed = 32'h23BE;
      repeat (16) @(posedge clock);
      `CHK(loop_mode, 2'b00)
      `CHK(crc_append, 1'b1)
      sys_rst <= 1'b0;
      rd(DMA_SETUP_OFS, d);
      `CHK(d, 8'h04)
      rd(TX_SETUP_OFS, d);
      `CHK(d, 8'h00)
      rd(4'h3, d);
      `CHK(d, 8'h00)
      // Setup first, then remote start address, random plus two corners
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         cfg = (i == 0) ? 8'h67 : (i == 1) ? 8'h00 : {1'b0, seed[6:0]};
         rsa = seed[23:8];
         wr(DMA_SETUP_OFS, cfg);
         wr(RSA_LO_OFS, rsa[7:0]);
         wr(RSA_HI_OFS, rsa[15:8]);
         rd(DMA_SETUP_OFS, d);
         `CHK(d, cfg)
         chk_path(20);
      end
      // Every loop mode with loopback select both ways, CRC both ways
      for (int k = 0; k < 16; k++) begin
         cfg = {4'h0, k[3], 3'b000};
         wr(DMA_SETUP_OFS, cfg);
         wr(TX_SETUP_OFS, {5'h00, k[1:0], k[2]});
         @(posedge clock);
         #1;
         `CHK(loop_mode, k[3] ? 2'b00 : k[1:0])
         `CHK(loopback_pin_out, !k[3] && k[1:0] == 2'b10)
         `CHK(crc_append, !k[2])
      end
      // Send with auto-remove off then on, start pulse lasting one cycle
      for (int k = 0; k < 2; k++) begin
         wr(DMA_SETUP_OFS, {3'b000, k[0], 4'h0});
         wr(CMD_OFS, 8'h10);
         `CHK(snap, k[0])
         #1;
         `CHK(remote_dma_start, 1'b0)
      end
      // Remote disable: ignored when off, then stop and restart
      hit(6'h3E, 1'b1);
      wr(TX_SETUP_OFS, 8'h08);
      hit(6'h3E, 1'b0);
      hit({1'b0, seed[4:0]}, 1'b0);
      hit(6'h3F, 1'b1);
      hit(6'h3E, 1'b0);
      wr(TX_SETUP_OFS, 8'h00);
      #1;
      `CHK(tx_enable, 1'b1)
      // Seed bit 0 is forced high, so a collision right after draws exactly one slot
      reg_addr <= SEED_OFS;
      reg_wdata <= 8'h5A;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      coll_pulse <= 1'b1;
      @(posedge clock);
      coll_pulse <= 1'b0;
      rd(STATUS_OFS, d);
      `CHK(d[4:0], 5'h03)
      n = 0;
      while (backoff_busy === 1'b1 && n < 7000) begin
         @(posedge clock);
         n++;
      end
      `CHK(n <= SLOT_CYCLES + 8, 1'b1)
      `CHK(n >= SLOT_CYCLES - 8, 1'b1)
      tx_done <= 1'b1;
      @(posedge clock);
      tx_done <= 1'b0;
      rd(STATUS_OFS, d);
      `CHK(d[4:1], 4'h0)
      // Priority backoff exercised; a frozen clock enable drops writes
      wr(TX_SETUP_OFS, 8'h10);
      coll_pulse <= 1'b1;
      @(posedge clock);
      coll_pulse <= 1'b0;
      clk_en <= 1'b0;
      wr(TX_SETUP_OFS, 8'h04);
      #1;
      `CHK(loop_mode, 2'b00)
      clk_en <= 1'b1;
      end_of_test();
   end
endmodule
`default_nettype wire
